// ==== rtl/dtec_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "dtec_map.vh"

module dtec_top (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_counter0_input_pin,
  input wire i_counter1_input_pin,
  output reg o_counter0_irq,
  output reg o_counter1_irq,
  output reg o_wake
);

  // ======================================================
  // reset release
  reg rst_s1_q;
  reg rst_n_q;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ======================================================
  // internal time bases
  wire instr_tick;
  wire slow_tick;

  dtec_tick #(
    .STEP(28'h0000001),
    .MOD(`DTEC_INSTR_DIV)
  ) u_instr_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_q),
    .o_tick(instr_tick)
  );

  dtec_tick #(
    .STEP(`DTEC_SLOW_HZ),
    .MOD(`DTEC_SYS_HZ)
  ) u_slow_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_q),
    .o_tick(slow_tick)
  );

  // ======================================================
  // wishbone decode
  wire [5:0] idx = i_wb_adr[7:2];
  wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // side effects act on the edge that raises ack, request is stable then
  wire wr = req & i_wb_we & i_wb_sel[0];
  wire rd = req & ~i_wb_we;
  wire [7:0] wdat = i_wb_dat[7:0];

  wire [1:0] wr_high;
  wire [1:0] wr_low;
  wire [1:0] wr_ctrl;
  wire [1:0] rd_high;
  wire wr_ien = wr & (idx == `DTEC_IDX_IRQ_EN);
  wire wr_flags = wr & (idx == `DTEC_IDX_FLAGS);

  assign wr_high[0] = wr & (idx == `DTEC_IDX_C0_HIGH);
  assign wr_high[1] = wr & (idx == `DTEC_IDX_C1_HIGH);
  assign wr_low[0] = wr & (idx == `DTEC_IDX_C0_LOW);
  assign wr_low[1] = wr & (idx == `DTEC_IDX_C1_LOW);
  assign wr_ctrl[0] = wr & (idx == `DTEC_IDX_C0_CTRL);
  assign wr_ctrl[1] = wr & (idx == `DTEC_IDX_C1_CTRL);
  assign rd_high[0] = rd & (idx == `DTEC_IDX_C0_HIGH);
  assign rd_high[1] = rd & (idx == `DTEC_IDX_C1_HIGH);

  // ======================================================
  // per-counter state exported flat for the read mux, request and wake outputs
  wire [1:0] pin_in = {i_counter1_input_pin, i_counter0_input_pin};
  wire [1:0] int_tick = {slow_tick, instr_tick};
  wire [31:0] cnt_v;
  wire [15:0] buf_v;
  wire [15:0] ctrl_v;
  wire [1:0] flag_v;
  wire [1:0] flag_d_v;
  wire [1:0] ovf_v;

  reg [1:0] ien_q;
  // reset value of the edge select, taken from the control reset word
  localparam [7:0] CTRL_RST = `DTEC_CTRL_RESET;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cnt
      reg [15:0] cnt_q;
      reg [15:0] pre_q;
      reg [7:0] buf_q;
      reg edge_q;
      reg on_q;
      reg [1:0] mode_q;
      reg meas_q;
      reg pin_prev_q;
      reg flag_q;

      wire pin = pin_in[g];
      wire rise = pin & ~pin_prev_q;
      wire fall = ~pin & pin_prev_q;
      wire m_event = (mode_q == `DTEC_MODE_EVENT);
      wire m_timer = (mode_q == `DTEC_MODE_TIMER);
      wire m_pulse = (mode_q == `DTEC_MODE_PULSE);
      // event edge: 0 rising, 1 falling
      wire ev_edge = edge_q ? fall : rise;
      // pulse: 1 measures high (starts rising), 0 measures low
      wire p_start = on_q & ~meas_q & (edge_q ? rise : fall);
      wire p_end = meas_q & (edge_q ? fall : rise);
      wire step = on_q & ((m_event & ev_edge) | (m_timer & int_tick[g]) |
                  (m_pulse & meas_q & int_tick[g]));
      wire wrap = step & (cnt_q == `DTEC_COUNT_MAX);
      wire [15:0] new_pre = {wdat, buf_q};
      wire flag_clr = wr_flags & wdat[g];
      wire flag_d = wrap | (flag_q & ~flag_clr);

      always @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          cnt_q <= 16'h0000;
          pre_q <= 16'h0000;
          buf_q <= 8'h00;
          edge_q <= CTRL_RST[`DTEC_CTRL_EDGE];
          on_q <= 1'b0;
          mode_q <= `DTEC_MODE_NONE;
          meas_q <= 1'b0;
          pin_prev_q <= 1'b0;
          flag_q <= 1'b0;
        end else begin
          pin_prev_q <= pin;
          flag_q <= flag_d;
          // counter
          if (wrap) begin
            cnt_q <= pre_q;
          end else if (step) begin
            cnt_q <= cnt_q + 16'h0001;
          end else if (wr_high[g] && !on_q) begin
            cnt_q <= new_pre;
          end
          // preload only; running counter picks it up at the next wrap
          if (wr_high[g]) begin
            pre_q <= new_pre;
          end
          if (wr_low[g]) begin
            buf_q <= wdat;
          end else if (rd_high[g]) begin
            buf_q <= cnt_q[7:0];
          end
          // control and pulse measurement sequencing
          if (wr_ctrl[g]) begin
            edge_q <= wdat[`DTEC_CTRL_EDGE];
            on_q <= wdat[`DTEC_CTRL_ON];
            mode_q <= wdat[`DTEC_CTRL_MODE_HI:`DTEC_CTRL_MODE_LO];
            meas_q <= 1'b0;
          end else if (m_pulse) begin
            if (p_start) begin
              meas_q <= 1'b1;
            end else if (p_end) begin
              meas_q <= 1'b0;
              on_q <= 1'b0;
            end
          end else begin
            meas_q <= 1'b0;
          end
        end
      end

      assign cnt_v[16*g +: 16] = cnt_q;
      assign buf_v[8*g +: 8] = buf_q;
      // bits 2:0 and 5 read as zero
      assign ctrl_v[8*g +: 8] = {mode_q, 1'b0, on_q, edge_q, 3'h0};
      assign flag_v[g] = flag_q;
      assign flag_d_v[g] = flag_d;
      // wake leaves with the request, both one edge after the wrap
      assign ovf_v[g] = wrap;
    end
  endgenerate

  // ======================================================
  // read mux, unmapped reads return zero
  reg [7:0] rdat;

  always @* begin
    case (idx)
      `DTEC_IDX_C0_HIGH: rdat = cnt_v[15:8];
      `DTEC_IDX_C0_LOW: rdat = buf_v[7:0];
      `DTEC_IDX_C0_CTRL: rdat = ctrl_v[7:0];
      `DTEC_IDX_C1_HIGH: rdat = cnt_v[31:24];
      `DTEC_IDX_C1_LOW: rdat = buf_v[15:8];
      `DTEC_IDX_C1_CTRL: rdat = ctrl_v[15:8];
      `DTEC_IDX_IRQ_EN: rdat = {6'h00, ien_q};
      `DTEC_IDX_FLAGS: rdat = {6'h00, flag_v};
      default: rdat = 8'h00;
    endcase
  end

  // ======================================================
  // bus answer, enables and request outputs
  // next enable so a write to it moves the request on the same edge
  wire [1:0] ien_d = wr_ien ? wdat[1:0] : ien_q;

  always @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ien_q <= 2'h0;
      o_counter0_irq <= 1'b0;
      o_counter1_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_wb_ack <= req;
      if (rd) begin
        o_wb_dat <= {24'h000000, rdat};
      end
      ien_q <= ien_d;
      o_counter0_irq <= flag_d_v[0] & ien_d[0];
      o_counter1_irq <= flag_d_v[1] & ien_d[1];
      o_wake <= |ovf_v;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/dtec_map.vh ====
// Function
// - each counter is 16-bit up-counter, clock from its pin or internal source
// - counter 0 internal source is system clock divided by four
// - counter 1 internal source is a 32768Hz tick
// - low byte write only fills the holding buffer, preload unchanged
// - high byte write loads preload with high byte and buffered low byte
// - high byte read returns live high byte, latches live low byte into buffer
// - low byte read returns holding buffer, never the live low count
// - control bits 7:6 select mode: 01 event, 10 timer, 11 pulse width
// - event mode: edge select 0 counts rising, 1 counts falling edges
// - pulse width mode: edge select 0 measures low, 1 measures high pulse
// - counter-on bit 0 stops counting, 1 lets it count
// - event/timer count up; past FFFF reload preload and set request flag
// - pulse mode counts from chosen transition to return, then clears on bit
// - after one measurement result holds until software sets on bit again
// - pulse measurement starts on a transition, not on the present level
// - pulse mode overflow reloads, keeps measuring and sets request flag
// - event/timer modes never clear the on bit by hardware
// - every counter overflow is a wake-up event
// - interrupt enable 0 blocks the overflow request in every mode
// - stopped counter: preload update also loads the counter
// - running counter: preload update touches preload only
`ifndef DTEC_MAP_VH
`define DTEC_MAP_VH

// ======================================================
// register indices, byte address is four times index
`define DTEC_IDX_C0_HIGH 6'h0C
`define DTEC_IDX_C0_LOW 6'h0D
`define DTEC_IDX_C0_CTRL 6'h0E
`define DTEC_IDX_C1_HIGH 6'h0F
`define DTEC_IDX_C1_LOW 6'h10
`define DTEC_IDX_C1_CTRL 6'h11
`define DTEC_IDX_IRQ_EN 6'h12
`define DTEC_IDX_FLAGS 6'h13

// ======================================================
// control fields
`define DTEC_CTRL_EDGE 3
`define DTEC_CTRL_ON 4
`define DTEC_CTRL_MODE_LO 6
`define DTEC_CTRL_MODE_HI 7
`define DTEC_MODE_NONE 2'h0
`define DTEC_MODE_EVENT 2'h1
`define DTEC_MODE_TIMER 2'h2
`define DTEC_MODE_PULSE 2'h3
`define DTEC_CTRL_RESET 8'h08
`define DTEC_COUNT_MAX 16'hFFFF

// ======================================================
// timing
`define DTEC_SYS_HZ 28'h5F5E100
`define DTEC_SLOW_HZ 28'h0008000
`define DTEC_INSTR_DIV 28'h0000004

`endif

// ==== rtl/dtec_tick.v ====
`timescale 1ns/100ps
`default_nettype none

// ======================================================
// fractional tick: one pulse per MOD/STEP clocks on average
module dtec_tick #(
  parameter [27:0] STEP = 28'h0000001,
  parameter [27:0] MOD = 28'h0000004
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  output reg o_tick
);

  reg [27:0] acc_q;
  wire [28:0] sum = {1'b0, acc_q} + {1'b0, STEP};
  wire wrap = (sum >= {1'b0, MOD});

  // phase accumulator keeps long-term rate exact, jitter is one clock
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q <= 28'h0000000;
      o_tick <= 1'b0;
    end else begin
      o_tick <= wrap;
      if (wrap) begin
        acc_q <= sum[27:0] - MOD;
      end else begin
        acc_q <= sum[27:0];
      end
    end
  end

endmodule

`default_nettype wire

// ==== verification/dtec_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dtec_map.vh"
module dtec_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_counter0_input_pin,
  input wire logic i_counter1_input_pin,
  input wire logic o_counter0_irq,
  input wire logic o_counter1_irq,
  input wire logic o_wake
);
  // ==========
  // bus and request relations
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_ACK_LAT: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  AST_ACK_ONE: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  AST_NO_REQ: assert property (
    !i_wb_cyc |=> !o_wb_ack) else $error("ack without request");
  AST_RD_HOLD: assert property (
    !(o_wb_ack && !$past(i_wb_we)) |-> $stable(o_wb_dat))
    else $error("read data moved");
  AST_CTRL_ZERO: assert property (
    o_wb_ack && !$past(i_wb_we) && ($past(i_wb_adr[7:2]) ==
    `DTEC_IDX_C0_CTRL || $past(i_wb_adr[7:2]) == `DTEC_IDX_C1_CTRL)
    |-> o_wb_dat[2:0] == 3'h0) else $error("control low bits set");
  // irq may only drop on a bus write, so it never self-clears
  AST_IRQ0_FALL: assert property (
    $fell(o_counter0_irq) |-> o_wb_ack && $past(i_wb_we))
    else $error("irq0 dropped");
  AST_IRQ1_FALL: assert property (
    $fell(o_counter1_irq) |-> o_wb_ack && $past(i_wb_we))
    else $error("irq1 dropped");
  AST_IRQ0_RISE: assert property (
    $rose(o_counter0_irq) |-> o_wake || (o_wb_ack && $past(i_wb_we)))
    else $error("irq0 without wake");
  AST_IRQ1_RISE: assert property (
    $rose(o_counter1_irq) |-> o_wake || (o_wb_ack && $past(i_wb_we)))
    else $error("irq1 without wake");
endmodule
bind dtec_top dtec_assertions u_dtec_assertions (.*);
`default_nettype wire

// ==== verification/dtec_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtec_pin_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [7:0] i_n,
  input wire logic [7:0] i_w,
  output logic o_pin,
  output wire logic o_busy
);
  // ==========
  // burst of i_n pulses, i_w clocks per level
  logic [8:0] left = 9'h000;
  logic [7:0] t = 8'h00;
  initial o_pin = 1'b0;
  assign o_busy = left != 9'h000;
  always @(posedge i_sys_clk) begin
    if (i_go) begin
      left <= {i_n, 1'b0};
      t <= i_w;
    end else if (o_busy && t == 8'h01) begin
      o_pin <= ~o_pin;
      left <= left - 9'h001;
      t <= i_w;
    end else if (o_busy) begin
      t <= t - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dtec_map.vh"
module tb_top;
  // ==========
  // bench
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, go = 1'b0;
  logic [7:0] adr = 8'h00, n = 8'h00, w = 8'h00;
  logic [31:0] dat = 32'h0, q, rnd = 32'h9705;
  logic [15:0] v;
  wire [31:0] rdat;
  wire ack, pin, busy, irq0, irq1, wake;
  int errors = 0, checks = 0, wakes = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
  dtec_top u_dtec_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_counter0_input_pin(pin), .i_counter1_input_pin(pin),
    .o_counter0_irq(irq0), .o_counter1_irq(irq1), .o_wake(wake));
  dtec_pin_model u_dtec_pin_model (.i_sys_clk(clk), .i_go(go), .i_n(n),
    .i_w(w), .o_pin(pin), .o_busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, lo, hi);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: got %h", $time, g);
    end
  endtask
  // ack is awaited, never assumed; timeout ends the run
  task automatic wb(input logic wr_, input logic [5:0] i, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    we <= wr_;
    adr <= {i, 2'h0};
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, e, e);
  endtask
  task automatic ld(input logic [5:0] i, input logic [15:0] d);
    wb(1'b1, i + 6'h01, d[7:0]);
    wb(1'b1, i, d[15:8]);
  endtask
  task automatic r16(input logic [5:0] i, input logic [15:0] lo, hi);
    wb(1'b0, i, 8'h00);
    v[15:8] = q[7:0];
    wb(1'b0, i + 6'h01, 8'h00);
    v[7:0] = q[7:0];
    chk(v, lo, hi);
  endtask
  task automatic pulses(input logic [7:0] c, h);
    int k;
    @(posedge clk);
    go <= 1'b1;
    n <= c;
    w <= h;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy === 1'b1 && k < 5000);
    if (k >= 5000) begin
      errors++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`DTEC_IDX_C0_CTRL, 8'h08);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'hFF);
    rc(`DTEC_IDX_C0_CTRL, 8'hD8);
    r16(`DTEC_IDX_C0_HIGH, 16'h0000, 16'h0000);
    wb(1'b1, 6'h3F, 8'hFF);
    rc(6'h3F, 8'h00);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h08);
    repeat (3) begin
      rnd = lfsr(rnd);
      ld(`DTEC_IDX_C0_HIGH, rnd[15:0]);
      r16(`DTEC_IDX_C0_HIGH, rnd[15:0], rnd[15:0]);
    end
    wb(1'b1, `DTEC_IDX_C0_LOW, ~rnd[7:0]);
    r16(`DTEC_IDX_C0_HIGH, rnd[15:0], rnd[15:0]);
    wb(1'b1, `DTEC_IDX_C0_LOW, 8'h5A);
    rc(`DTEC_IDX_C0_LOW, 8'h5A);
    ld(`DTEC_IDX_C0_HIGH, 16'hFFF0);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h50);
    pulses(8'h05, 8'h03);
    r16(`DTEC_IDX_C0_HIGH, 16'hFFF5, 16'hFFF5);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h58);
    pulses(8'h0B, 8'h03);
    r16(`DTEC_IDX_C0_HIGH, 16'hFFF0, 16'hFFF0);
    chk(wakes, 32'h1, 32'h1);
    chk(irq0, 32'h0, 32'h0);
    rc(`DTEC_IDX_C0_CTRL, 8'h58);
    ld(`DTEC_IDX_C0_HIGH, 16'h1234);
    r16(`DTEC_IDX_C0_HIGH, 16'hFFF0, 16'hFFF0);
    wb(1'b1, `DTEC_IDX_IRQ_EN, 8'h01);
    chk(irq0, 32'h1, 32'h1);
    wb(1'b1, `DTEC_IDX_FLAGS, 8'h01);
    chk(irq0, 32'h0, 32'h0);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h48);
    pulses(8'h02, 8'h03);
    r16(`DTEC_IDX_C0_HIGH, 16'hFFF0, 16'hFFF0);
    ld(`DTEC_IDX_C0_HIGH, 16'h0000);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'hD8);
    pulses(8'h01, 8'h28);
    r16(`DTEC_IDX_C0_HIGH, 16'h0009, 16'h000B);
    rc(`DTEC_IDX_C0_CTRL, 8'hC8);
    pulses(8'h01, 8'h28);
    r16(`DTEC_IDX_C0_HIGH, 16'h0009, 16'h000B);
    ld(`DTEC_IDX_C0_HIGH, 16'h0000);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h90);
    repeat (400) @(posedge clk);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h80);
    r16(`DTEC_IDX_C0_HIGH, 16'h0063, 16'h0066);
    ld(`DTEC_IDX_C0_HIGH, 16'h0000);
    wb(1'b1, `DTEC_IDX_C0_CTRL, 8'h10);
    repeat (40) @(posedge clk);
    r16(`DTEC_IDX_C0_HIGH, 16'h0000, 16'h0000);
    wb(1'b1, `DTEC_IDX_C1_CTRL, 8'h90);
    repeat (12208) @(posedge clk);
    wb(1'b1, `DTEC_IDX_C1_CTRL, 8'h80);
    r16(`DTEC_IDX_C1_HIGH, 16'h0003, 16'h0005);
    chk(irq1, 32'h0, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
